// file: hdl/token_host.v
// Function
// - write zero requests, same port's one releases
// - poller deasserts select between successive reads
// - request by writing zero, then read back
// - failed requester re-reads or writes one
// - software writes one to all flags first
// - flag access: memory select high, no overlap
`timescale 1ns/1ns
`include "token_host_defs.vh"

module token_host
(
  input  wire                     clk_i,
  input  wire                     arst_n_i,
  input  wire                     cmd_valid_i,
  input  wire [1:0]               cmd_op_i,
  input  wire [`TOK_IDX_W-1:0]    cmd_index_i,
  input  wire                     cmd_withdraw_i,
  output wire                     cmd_ready_o,
  output wire                     done_o,
  output wire                     granted_o,
  output wire                     flag_value_o,
  output wire                     port_select_n_o,
  output wire                     token_space_select_n_o,
  output wire                     read_write_n_o,
  output wire                     output_drive_enable_n_o,
  output wire [`TOK_ADDR_W-1:0]   addr_o,
  output wire [`TOK_DATA_W-1:0]   data_o,
  output wire                     data_oe_n_o,
  input  wire [`TOK_DATA_W-1:0]   data_i
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_WSET   = 3'h1;
  localparam [2:0] S_WPULSE = 3'h2;
  localparam [2:0] S_WEND   = 3'h3;
  localparam [2:0] S_RPULSE = 3'h4;
  localparam [2:0] S_GAP    = 3'h5;
  localparam integer WR_CYC_I  = `TOK_WR_PULSE_CYC;
  localparam integer RD_CYC_I  = `TOK_RD_ACCESS_CYC;
  localparam integer GAP_CYC_I = `TOK_GAP_CYC;
  localparam [3:0]   WR_CYC    = WR_CYC_I[3:0];
  localparam [3:0]   RD_CYC    = RD_CYC_I[3:0];
  localparam [3:0]   GAP_CYC   = GAP_CYC_I[3:0];
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg [1:0] rst_sync_reg;
  wire      rst_n;
  // two-stage release of the asynchronous reset
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];
  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  reg [2:0]             state_reg,    state_next;
  reg [3:0]             cnt_reg,      cnt_next;
  reg [1:0]             op_reg,       op_next;
  reg [`TOK_IDX_W-1:0]  idx_reg,      idx_next;
  reg                   withdraw_reg, withdraw_next;
  reg                   wbit_reg,     wbit_next;
  reg                   rd_pend_reg,  rd_pend_next;
  reg                   wr_pend_reg,  wr_pend_next;
  reg                   done_reg,     done_next;
  reg                   grant_reg,    grant_next;
  reg                   value_reg,    value_next;
  reg                   sel_n_reg,    sel_n_next;
  reg                   rw_n_reg,     rw_n_next;
  reg                   oe_n_reg,     oe_n_next;
  reg                   doe_n_reg,    doe_n_next;
  // count reached its last cycle
  function cnt_last;
    input [3:0] cnt;
    begin
      cnt_last = (cnt == 4'h1);
    end
  endfunction
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always @*
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    op_next       = op_reg;
    idx_next      = idx_reg;
    withdraw_next = withdraw_reg;
    wbit_next     = wbit_reg;
    rd_pend_next  = rd_pend_reg;
    wr_pend_next  = wr_pend_reg;
    done_next     = 1'b0;
    grant_next    = grant_reg;
    value_next    = value_reg;
    sel_n_next    = sel_n_reg;
    rw_n_next     = rw_n_reg;
    oe_n_next     = oe_n_reg;
    doe_n_next    = doe_n_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (cmd_valid_i)
        begin
          op_next       = cmd_op_i;
          idx_next      = cmd_index_i;
          withdraw_next = cmd_withdraw_i;
          if (cmd_op_i == `TOK_OP_POLL)
          begin
            // read only: select and enable low together
            state_next = S_RPULSE;
            cnt_next   = RD_CYC;
            sel_n_next = 1'b0;
            oe_n_next  = 1'b0;
          end
          else
          begin
            // acquire writes zero, release and init write one
            wbit_next    = (cmd_op_i != `TOK_OP_ACQUIRE);
            rd_pend_next = (cmd_op_i == `TOK_OP_ACQUIRE);
            if (cmd_op_i == `TOK_OP_INIT)
              idx_next = {`TOK_IDX_W{1'b0}};
            state_next = S_WSET;
          end
        end
      end
      S_WSET:
      begin
        // address and data settle before the strobe
        rw_n_next  = 1'b0;
        doe_n_next = 1'b0;
        sel_n_next = 1'b0;
        cnt_next   = WR_CYC;
        state_next = S_WPULSE;
      end
      S_WPULSE:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_last(cnt_reg))
        begin
          // trailing edge: select rises while data still driven
          sel_n_next = 1'b1;
          state_next = S_WEND;
        end
      end
      S_WEND:
      begin
        rw_n_next  = 1'b1;
        doe_n_next = 1'b1;
        cnt_next   = GAP_CYC;
        state_next = S_GAP;
        if (op_reg == `TOK_OP_RELEASE)
          grant_next = 1'b0;
      end
      S_RPULSE:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_last(cnt_reg))
        begin
          // all bits carry the flag; bit zero is taken
          value_next = data_i[0];
          // zero back means this port owns the token
          if (op_reg == `TOK_OP_ACQUIRE)
          begin
            grant_next   = ~data_i[0];
            wr_pend_next = data_i[0] & withdraw_reg;
          end
          // end the read so the next read relatches
          sel_n_next = 1'b1;
          oe_n_next  = 1'b1;
          cnt_next   = GAP_CYC;
          state_next = S_GAP;
        end
      end
      S_GAP:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_last(cnt_reg))
        begin
          if (rd_pend_reg)
          begin
            // read back after the request write
            rd_pend_next = 1'b0;
            sel_n_next   = 1'b0;
            oe_n_next    = 1'b0;
            cnt_next     = RD_CYC;
            state_next   = S_RPULSE;
          end
          else if (wr_pend_reg)
          begin
            // withdraw a failed request so it cannot hang later
            wr_pend_next = 1'b0;
            wbit_next    = 1'b1;
            state_next   = S_WSET;
          end
          else if ((op_reg == `TOK_OP_INIT) && (idx_reg != `TOK_LAST_IDX))
          begin
            idx_next   = idx_reg + 3'h1;
            state_next = S_WSET;
          end
          else
          begin
            done_next  = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      default:
      begin
        state_next = S_IDLE;
        sel_n_next = 1'b1;
        rw_n_next  = 1'b1;
        oe_n_next  = 1'b1;
        doe_n_next = 1'b1;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // all pins idle in standby after reset
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= S_IDLE;
      cnt_reg      <= 4'h0;
      op_reg       <= `TOK_OP_ACQUIRE;
      idx_reg      <= {`TOK_IDX_W{1'b0}};
      withdraw_reg <= 1'b0;
      wbit_reg     <= 1'b1;
      rd_pend_reg  <= 1'b0;
      wr_pend_reg  <= 1'b0;
      done_reg     <= 1'b0;
      grant_reg    <= 1'b0;
      value_reg    <= 1'b1;
      sel_n_reg    <= 1'b1;
      rw_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      doe_n_reg    <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      op_reg       <= op_next;
      idx_reg      <= idx_next;
      withdraw_reg <= withdraw_next;
      wbit_reg     <= wbit_next;
      rd_pend_reg  <= rd_pend_next;
      wr_pend_reg  <= wr_pend_next;
      done_reg     <= done_next;
      grant_reg    <= grant_next;
      value_reg    <= value_next;
      sel_n_reg    <= sel_n_next;
      rw_n_reg     <= rw_n_next;
      oe_n_reg     <= oe_n_next;
      doe_n_reg    <= doe_n_next;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // memory select stays high so the two spaces never overlap
  assign port_select_n_o         = 1'b1;
  assign token_space_select_n_o  = sel_n_reg;
  assign read_write_n_o          = rw_n_reg;
  assign output_drive_enable_n_o = oe_n_reg;
  // flag chosen by the three low address lines only
  assign addr_o = {{(`TOK_ADDR_W-`TOK_IDX_W){1'b0}}, idx_reg};
  // written bit sits on data bit zero, replicated
  assign data_o      = {`TOK_DATA_W{wbit_reg}};
  assign data_oe_n_o = doe_n_reg;
  assign cmd_ready_o = (state_reg == S_IDLE);
  assign done_o       = done_reg;
  assign granted_o    = grant_reg;
  assign flag_value_o = value_reg;
endmodule // token_host

// file: inc/token_host_defs.vh
`ifndef TOKEN_HOST_DEFS_VH
`define TOKEN_HOST_DEFS_VH

// ----------------------------------------------------------------
// clock and pin timing
// ----------------------------------------------------------------
`define TOK_CLK_MHZ        125
`define TOK_WR_PULSE_NS    40
`define TOK_RD_ACCESS_NS   55
`define TOK_GAP_NS         20
// least times, rounded up to whole cycles
`define TOK_WR_PULSE_CYC   ((`TOK_WR_PULSE_NS * `TOK_CLK_MHZ + 999) / 1000)
`define TOK_RD_ACCESS_CYC  ((`TOK_RD_ACCESS_NS * `TOK_CLK_MHZ + 999) / 1000)
`define TOK_GAP_CYC        ((`TOK_GAP_NS * `TOK_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// command codes and pin layout
// ----------------------------------------------------------------
`define TOK_OP_ACQUIRE     2'h0
`define TOK_OP_RELEASE     2'h1
`define TOK_OP_POLL        2'h2
`define TOK_OP_INIT        2'h3
`define TOK_FLAG_COUNT     8
`define TOK_IDX_W          3
`define TOK_ADDR_W         13
`define TOK_DATA_W         8
`define TOK_LAST_IDX       3'h7

`endif

// file: verif/dual_port_token_flags_test.sv
`timescale 1ns/1ns
`include "token_host_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module dual_port_token_flags_test;
  logic clk_i, arst_n_i, cmd_valid_i, cmd_withdraw_i, r_wr, r_bit;
  logic [1:0] cmd_op_i;
  logic [2:0] cmd_index_i, r_idx;
  wire ready, done_o, granted_o, flag_value_o, psel, tsel, rw, oe, doe, r_view, l_req;
  wire [12:0] addr;
  wire [7:0] wd, rd;
  int failures = 0, n_tests = 0, cyc = 0;
  token_host DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_index_i(cmd_index_i), .cmd_withdraw_i(cmd_withdraw_i),
    .cmd_ready_o(ready), .done_o(done_o), .granted_o(granted_o), .flag_value_o(flag_value_o),
    .port_select_n_o(psel), .token_space_select_n_o(tsel), .read_write_n_o(rw),
    .output_drive_enable_n_o(oe), .addr_o(addr), .data_o(wd), .data_oe_n_o(doe), .data_i(rd));
  token_device_model dev (.clk_i(clk_i), .sel_n_i(tsel), .rw_n_i(rw), .oe_n_i(oe),
    .addr_i(addr), .wd_i(wd), .rd_o(rd), .r_wr_i(r_wr), .r_idx_i(r_idx), .r_bit_i(r_bit),
    .r_view_o(r_view), .l_req_o(l_req));
  // one host command, then wait for its completion pulse
  task automatic cmd(input logic [1:0] op, input logic [2:0] idx, input logic w);
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_index_i = idx;
    cmd_withdraw_i = w;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // one write from the far-side processor
  task automatic rwr(input logic [2:0] idx, input logic b);
    @(negedge clk_i);
    r_idx = idx;
    r_bit = b;
    r_wr = 1'b1;
    @(negedge clk_i);
    r_wr = 1'b0;
  endtask
  task automatic t_init;
    cmd(`TOK_OP_INIT, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
      rwr(i[2:0], 1'b1);
    `CHK(r_view, 1'b1)
    cmd(`TOK_OP_POLL, 3'h6, 1'b0);
    `CHK(flag_value_o, 1'b1)
  endtask
  task automatic t_grab;
    cmd(`TOK_OP_ACQUIRE, 3'h5, 1'b0);
    `CHK({granted_o, flag_value_o}, 2'h2)
    rwr(3'h5, 1'b0);
    `CHK(r_view, 1'b1)
    cmd(`TOK_OP_RELEASE, 3'h5, 1'b0);
    `CHK({granted_o, r_view}, 2'h0)
    cmd(`TOK_OP_POLL, 3'h5, 1'b0);
    `CHK(flag_value_o, 1'b1)
    rwr(3'h5, 1'b1);
  endtask
  task automatic t_withdraw;
    rwr(3'h2, 1'b0);
    cmd(`TOK_OP_ACQUIRE, 3'h2, 1'b1);
    `CHK({granted_o, flag_value_o, l_req}, 3'h3)
    rwr(3'h2, 1'b1);
    cmd(`TOK_OP_POLL, 3'h2, 1'b0);
    `CHK(flag_value_o, 1'b1)
  endtask
  task automatic t_pending;
    rwr(3'h7, 1'b0);
    cmd(`TOK_OP_ACQUIRE, 3'h7, 1'b0);
    `CHK({granted_o, l_req}, 2'h0)
    rwr(3'h7, 1'b1);
    cmd(`TOK_OP_POLL, 3'h7, 1'b0);
    `CHK({flag_value_o, r_view}, 2'h1)
    cmd(`TOK_OP_RELEASE, 3'h7, 1'b0);
    cmd(`TOK_OP_POLL, 3'h7, 1'b0);
    `CHK(flag_value_o, 1'b1)
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      summarize;
    end
  end
  initial
  begin
    arst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = 2'h0;
    cmd_index_i = 3'h0;
    cmd_withdraw_i = 1'b0;
    r_wr = 1'b0;
    r_idx = 3'h0;
    r_bit = 1'b1;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_init;
    t_grab;
    t_withdraw;
    t_pending;
    summarize;
  end
endmodule // dual_port_token_flags_test

// file: verif/token_device_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// two-sided token flag device, left side on the host pins
// ----------------------------------------------------------------
module token_device_model (
  input  wire        clk_i,
  input  wire        sel_n_i,
  input  wire        rw_n_i,
  input  wire        oe_n_i,
  input  wire [12:0] addr_i,
  input  wire [7:0]  wd_i,
  output wire [7:0]  rd_o,
  input  wire        r_wr_i,
  input  wire [2:0]  r_idx_i,
  input  wire        r_bit_i,
  output wire        r_view_o,
  output wire        l_req_o
);
  // owner per flag: 0 free, 1 left, 2 right
  logic [1:0] own [8];
  logic       req_l [8];
  logic       req_r [8];
  logic       lat = 1'b1;
  logic       rd_on = 1'b0;
  // power-up garbage: every flag held by the right side
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      own[i] = 2'h2;
      req_l[i] = 1'b1;
      req_r[i] = 1'b0;
    end
  end
  // request latch update and ownership hand-over
  task automatic upd(input bit rs, input logic [2:0] i, input logic v);
    logic [1:0] me;
    logic       oreq;
    me = rs ? 2'h2 : 2'h1;
    oreq = rs ? req_l[i] : req_r[i];
    if (rs)
      req_r[i] = v;
    else
      req_l[i] = v;
    if (v && own[i] == me)
      own[i] = oreq ? 2'h0 : (rs ? 2'h1 : 2'h2);
    else if (!v && own[i] == 2'h0)
      own[i] = me;
  endtask
  // left write lands at the trailing select edge, bit 0 only
  always @(posedge sel_n_i)
    if (!rw_n_i)
      upd(1'b0, addr_i[2:0], wd_i[0]);
  always @(posedge clk_i)
    if (r_wr_i)
      upd(1'b1, r_idx_i, r_bit_i);
  // read value frozen while select and enable stay low
  always @(negedge sel_n_i or negedge oe_n_i)
    if (!sel_n_i && !oe_n_i && rw_n_i)
    begin
      rd_on = 1'b1;
      lat = (own[addr_i[2:0]] != 2'h1);
    end
  always @(posedge sel_n_i or posedge oe_n_i)
    rd_on = 1'b0;
  // value on all bits; a released bus shows the inverse
  assign rd_o = rd_on ? {8{lat}} : ~{8{lat}};
  assign r_view_o = (own[r_idx_i] != 2'h2);
  assign l_req_o = req_l[r_idx_i];
endmodule // token_device_model

// file: verif/token_host_monitor.sv
`timescale 1ns/1ns
module token_host_monitor (
  input wire        clk_i,
  input wire        arst_n_i,
  input wire        cmd_valid_i,
  input wire        cmd_ready_o,
  input wire        done_o,
  input wire        granted_o,
  input wire        flag_value_o,
  input wire        port_select_n_o,
  input wire        token_space_select_n_o,
  input wire        read_write_n_o,
  input wire        output_drive_enable_n_o,
  input wire [12:0] addr_o,
  input wire [7:0]  data_o,
  input wire        data_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  mem_sel_off_a: assert property (port_select_n_o)
    else $error("memory select driven");
  hi_addr_zero_a: assert property (addr_o[12:3] == 10'h000)
    else $error("upper address bits set");
  wr_pulse_a: assert property ($fell(token_space_select_n_o) && !read_write_n_o
    |-> !token_space_select_n_o [*5] ##1 token_space_select_n_o) else $error("write pulse");
  wr_hold_a: assert property ($rose(token_space_select_n_o) && !read_write_n_o
    |-> $stable(data_o) && $stable(addr_o) && !data_oe_n_o) else $error("write hold");
  rd_pulse_a: assert property ($fell(output_drive_enable_n_o) |->
    (!token_space_select_n_o && read_write_n_o && data_oe_n_o) [*7] ##1 output_drive_enable_n_o)
    else $error("read cycle");
  wr_data_a: assert property (!data_oe_n_o |->
    !read_write_n_o && (data_o == 8'h00 || data_o == 8'hff)) else $error("write data");
  take_done_a: assert property (cmd_valid_i && cmd_ready_o |=>
    !cmd_ready_o ##[9:90] done_o) else $error("no completion");
  grant_read_a: assert property ($rose(granted_o) |-> !flag_value_o)
    else $error("grant without zero");
  cover property (cmd_valid_i && cmd_ready_o);
  cover property ($rose(granted_o));
  cover property (done_o && !granted_o && flag_value_o);
endmodule // token_host_monitor

bind token_host token_host_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
  .granted_o(granted_o), .flag_value_o(flag_value_o), .port_select_n_o(port_select_n_o),
  .token_space_select_n_o(token_space_select_n_o), .read_write_n_o(read_write_n_o),
  .output_drive_enable_n_o(output_drive_enable_n_o), .addr_o(addr_o), .data_o(data_o),
  .data_oe_n_o(data_oe_n_o));
